// File: hw/mac_cfg_pkg.sv
// package: offsets, field positions, reset values and carriers of the mac config bank
package mac_cfg_pkg;
	// ========================================
	// bus geometry and offsets
	localparam int unsigned ADDR_W          = 5;
	localparam int unsigned DATA_W          = 8;
	localparam logic [4:0]  OFF_INT_STATUS  = 5'h07;
	localparam logic [4:0]  OFF_FAE_TALLY   = 5'h0D;
	localparam logic [4:0]  OFF_DATA_CONFIG = 5'h0E;
	localparam logic [4:0]  OFF_CRC_TALLY   = 5'h0E;
	localparam logic [4:0]  OFF_INT_MASK    = 5'h0F;
	localparam logic [4:0]  OFF_RX_CONFIG   = 5'h1C;
	localparam logic [4:0]  OFF_TX_CONFIG   = 5'h1D;
	localparam logic [4:0]  OFF_RX_STATUS   = 5'h1E;
	localparam logic [4:0]  OFF_MEDIA_CTRL  = 5'h1F;

	// ========================================
	// field positions
	localparam int unsigned RC_MONITOR     = 5;
	localparam int unsigned RC_ALL_PHYS    = 4;
	localparam int unsigned RC_MCAST       = 3;
	localparam int unsigned RC_BCAST       = 2;
	localparam int unsigned RC_RUNT        = 1;
	localparam int unsigned RC_SAVE_ERR    = 0;
	localparam int unsigned TC_FULL_DUPLEX = 7;
	localparam int unsigned TC_PAD_DIS     = 6;
	localparam int unsigned TC_LATE_RETRY  = 5;
	localparam int unsigned TC_LOOP_HI     = 2;
	localparam int unsigned TC_LOOP_LO     = 1;
	localparam int unsigned TC_CRC_INHIBIT = 0;
	localparam int unsigned MC_FULL_DUPLEX = 7;
	localparam int unsigned DC_WORD_SEL    = 0;
	localparam int unsigned RS_RX_OFF      = 6;
	localparam int unsigned RS_MCAST       = 5;
	localparam int unsigned RS_MISSED      = 4;
	localparam int unsigned RS_FAE         = 2;
	localparam int unsigned RS_CRC         = 1;
	localparam int unsigned RS_INTACT      = 0;

	// ========================================
	// writable bit masks and reset values
	localparam logic [7:0] RC_MASK  = 8'h3F;
	localparam logic [7:0] TC_MASK  = 8'hE7;
	localparam logic [7:0] MC_MASK  = 8'h80;
	localparam logic [7:0] DC_MASK  = 8'h01;
	localparam logic [7:0] IM_MASK  = 8'h7F;
	localparam logic [7:0] RST_REG  = 8'h00;
	localparam int unsigned TALLY_W = 8;

	// ========================================
	// types
	typedef enum logic [1:0] {LOOP_NORMAL, LOOP_INTERNAL, LOOP_PHY, LOOP_RESERVED} loop_mode_t;

	typedef struct packed {
		logic multicast;
		logic broadcast;
		logic addrMatch;
		logic hashHit;
		logic runt;
		logic crcErr;
		logic alignErr;
	} rx_info_t;

	// bit order of the interrupt status and mask registers, bit 6 first
	typedef struct packed {
		logic dmaDone;
		logic tallyOverflow;
		logic ringOverrun;
		logic txError;
		logic rxError;
		logic txDone;
		logic rxDone;
	} irq_vec_t;

	typedef struct packed {
		logic       monitorOnly;
		logic       acceptAllPhysical;
		logic       acceptMulticast;
		logic       acceptBroadcast;
		logic       acceptRunt;
		logic       saveErrorPacket;
		logic       fullDuplex;
		logic       padDisable;
		logic       lateCollisionRetry;
		loop_mode_t loopbackMode;
		logic       crcInhibit;
		logic       dataPortWordSel;
	} mac_cfg_t;
endpackage : mac_cfg_pkg

// File: hw/mac_rx_tx_config_regs.sv
// mac receive/transmit configuration, status and tally register bank
//
// Overview of operation
// - monitor mode checks packets but never stores
// - promiscuous accepts every physical-address packet
// - multicast accepted only when hash filter hits
// - broadcast accepted only with broadcast enable, except with multicast flag clear (physical-address path)
// - runt packets kept only with runt enable
// - error packets kept only with save-error enable
// - full duplex is OR of two duplex bits
// - internal phy ignores both duplex bits
// - pad short frames unless pad disabled
// - retry late collisions only when enabled
// - two-bit field selects loop-back mode
// - append crc unless crc inhibited
// - count alignment errors on address-accepted packets
// - count crc errors on address-accepted packets
// - tally counters clear when host reads
// - width bit picks byte or word port
// - shared offset writes config, reads crc tally
// - seven interrupt enables, all off after reset
// - status bits sticky, cleared by writing one
// - tally msb set raises overflow status
`timescale 1ns/1ps
module mac_rx_tx_config_regs (
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	// host local bus, strobes one cycle wide
	input  wire logic                    hostCs,
	input  wire logic                    hostRd,
	input  wire logic                    hostWr,
	input  wire logic [4:0]              hostAddr,
	input  wire logic [7:0]              hostDataIn,
	output logic [7:0]                   hostDataOut,
	output logic                         hostDataOe,
	// receive side
	input  wire logic                    rxDone,
	input  wire mac_cfg_pkg::rx_info_t   rxInfo,
	input  wire logic                    rxMissed,
	input  wire logic                    receiverOff,
	output logic                         rxAccept,
	output logic                         rxStore,
	// transmit and dma events
	input  wire logic                    txDone,
	input  wire logic                    txError,
	input  wire logic                    dmaDone,
	input  wire logic                    ringOverrun,
	input  wire logic                    internalPhyUsed,
	output mac_cfg_pkg::mac_cfg_t        macCfg,
	output logic                         intReq
);
	// ========================================
	// address decode
	function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
		hit = (addr == off);
	endfunction : hit

	logic rdStrobe;
	logic wrStrobe;
	logic wrRxCfg;
	logic wrTxCfg;
	logic wrMedia;
	logic wrDataCfg;
	logic wrIntMask;
	logic wrIntStat;
	logic rdFaeTally;
	logic rdCrcTally;

	assign rdStrobe   = hostCs & hostRd;
	assign wrStrobe   = hostCs & hostWr;
	assign wrRxCfg    = wrStrobe & hit(hostAddr, mac_cfg_pkg::OFF_RX_CONFIG);
	assign wrTxCfg    = wrStrobe & hit(hostAddr, mac_cfg_pkg::OFF_TX_CONFIG);
	assign wrMedia    = wrStrobe & hit(hostAddr, mac_cfg_pkg::OFF_MEDIA_CTRL);
	assign wrDataCfg  = wrStrobe & hit(hostAddr, mac_cfg_pkg::OFF_DATA_CONFIG);
	assign wrIntMask  = wrStrobe & hit(hostAddr, mac_cfg_pkg::OFF_INT_MASK);
	assign wrIntStat  = wrStrobe & hit(hostAddr, mac_cfg_pkg::OFF_INT_STATUS);
	assign rdFaeTally = rdStrobe & hit(hostAddr, mac_cfg_pkg::OFF_FAE_TALLY);
	assign rdCrcTally = rdStrobe & hit(hostAddr, mac_cfg_pkg::OFF_CRC_TALLY);

	// ========================================
	// configuration registers
	logic [7:0] rxCfg_q;
	logic [7:0] txCfg_q;
	logic [7:0] media_q;
	logic [7:0] dataCfg_q;
	logic [7:0] intMask_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxCfg_q   <= mac_cfg_pkg::RST_REG;
			txCfg_q   <= mac_cfg_pkg::RST_REG;
			media_q   <= mac_cfg_pkg::RST_REG;
			dataCfg_q <= mac_cfg_pkg::RST_REG;
			intMask_q <= mac_cfg_pkg::RST_REG;
		end else begin
			if (wrRxCfg)
				rxCfg_q <= hostDataIn & mac_cfg_pkg::RC_MASK;
			if (wrTxCfg)
				txCfg_q <= hostDataIn & mac_cfg_pkg::TC_MASK;
			if (wrMedia)
				media_q <= hostDataIn & mac_cfg_pkg::MC_MASK;
			if (wrDataCfg)
				dataCfg_q <= hostDataIn & mac_cfg_pkg::DC_MASK;
			if (wrIntMask)
				intMask_q <= hostDataIn & mac_cfg_pkg::IM_MASK;
		end
	end

	// ========================================
	// receive filter
	logic anyErr;
	logic addrOk;
	logic acceptNow;
	logic intactNow;

	assign anyErr = rxInfo.crcErr | rxInfo.alignErr;
	assign addrOk =
		(rxInfo.broadcast & rxCfg_q[mac_cfg_pkg::RC_BCAST]) |
		(rxInfo.multicast & ~rxInfo.broadcast & rxCfg_q[mac_cfg_pkg::RC_MCAST]
			& rxInfo.hashHit) |
		(~rxInfo.multicast & (rxInfo.addrMatch | rxCfg_q[mac_cfg_pkg::RC_ALL_PHYS]));
	assign acceptNow = addrOk
		& (~rxInfo.runt | rxCfg_q[mac_cfg_pkg::RC_RUNT])
		& (~anyErr | rxCfg_q[mac_cfg_pkg::RC_SAVE_ERR]);
	assign intactNow = addrOk & ~anyErr & ~rxInfo.runt;

	logic [7:0] rxStat_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxAccept <= 1'b0;
			rxStore  <= 1'b0;
			rxStat_q <= mac_cfg_pkg::RST_REG;
		end else begin
			rxAccept <= rxDone & acceptNow;
			rxStore  <= rxDone & acceptNow & ~rxCfg_q[mac_cfg_pkg::RC_MONITOR];
			rxStat_q[mac_cfg_pkg::RS_RX_OFF] <= receiverOff;
			if (rxDone) begin
				rxStat_q[mac_cfg_pkg::RS_MCAST]  <= rxInfo.multicast;
				rxStat_q[mac_cfg_pkg::RS_FAE]    <= rxInfo.alignErr;
				rxStat_q[mac_cfg_pkg::RS_CRC]    <= rxInfo.crcErr;
				rxStat_q[mac_cfg_pkg::RS_INTACT] <= intactNow;
			end
			if (rxMissed)
				rxStat_q[mac_cfg_pkg::RS_MISSED] <= 1'b1;
			else if (rxDone)
				rxStat_q[mac_cfg_pkg::RS_MISSED] <= 1'b0;
		end
	end

	// ========================================
	// error tally counters
	logic [7:0] faeTally;
	logic [7:0] crcTally;
	logic       faeMsbRise;
	logic       crcMsbRise;

	tally_counter #(.WIDTH(mac_cfg_pkg::TALLY_W)) faeCounter (
		.core_clk  (core_clk),
		.rst       (rst),
		.countEn   (rxDone & addrOk & rxInfo.alignErr),
		.readClr   (rdFaeTally),
		.count_q   (faeTally),
		.msbRise_q (faeMsbRise)
	);

	tally_counter #(.WIDTH(mac_cfg_pkg::TALLY_W)) crcCounter (
		.core_clk  (core_clk),
		.rst       (rst),
		.countEn   (rxDone & addrOk & rxInfo.crcErr),
		.readClr   (rdCrcTally),
		.count_q   (crcTally),
		.msbRise_q (crcMsbRise)
	);

	// ========================================
	// interrupt status and request
	mac_cfg_pkg::irq_vec_t events;
	mac_cfg_pkg::irq_vec_t intStat_q;
	mac_cfg_pkg::irq_vec_t intStat_d;

	assign events.dmaDone       = dmaDone;
	assign events.tallyOverflow = faeMsbRise | crcMsbRise;
	assign events.ringOverrun   = ringOverrun;
	assign events.txError       = txError;
	assign events.rxError       = (rxDone & addrOk & anyErr) | rxMissed;
	assign events.txDone        = txDone;
	assign events.rxDone        = rxDone & intactNow;

	// a new event wins over a write-one clear in the same cycle
	assign intStat_d = (intStat_q & ~(wrIntStat ? hostDataIn[6:0] : 7'h00)) | events;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			intStat_q <= '0;
			intReq    <= 1'b0;
		end else begin
			intStat_q <= intStat_d;
			intReq    <= |(intStat_d & intMask_q[6:0]);
		end
	end

	// ========================================
	// mac configuration outputs
	logic fullDuplexNow;

	assign fullDuplexNow = ~internalPhyUsed
		& (txCfg_q[mac_cfg_pkg::TC_FULL_DUPLEX] | media_q[mac_cfg_pkg::MC_FULL_DUPLEX]);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			macCfg <= '0;
		end else begin
			macCfg.monitorOnly        <= rxCfg_q[mac_cfg_pkg::RC_MONITOR];
			macCfg.acceptAllPhysical  <= rxCfg_q[mac_cfg_pkg::RC_ALL_PHYS];
			macCfg.acceptMulticast    <= rxCfg_q[mac_cfg_pkg::RC_MCAST];
			macCfg.acceptBroadcast    <= rxCfg_q[mac_cfg_pkg::RC_BCAST];
			macCfg.acceptRunt         <= rxCfg_q[mac_cfg_pkg::RC_RUNT];
			macCfg.saveErrorPacket    <= rxCfg_q[mac_cfg_pkg::RC_SAVE_ERR];
			macCfg.fullDuplex         <= fullDuplexNow;
			macCfg.padDisable         <= txCfg_q[mac_cfg_pkg::TC_PAD_DIS];
			macCfg.lateCollisionRetry <= txCfg_q[mac_cfg_pkg::TC_LATE_RETRY];
			macCfg.loopbackMode       <= mac_cfg_pkg::loop_mode_t'(
				txCfg_q[mac_cfg_pkg::TC_LOOP_HI:mac_cfg_pkg::TC_LOOP_LO]);
			macCfg.crcInhibit         <= txCfg_q[mac_cfg_pkg::TC_CRC_INHIBIT];
			macCfg.dataPortWordSel    <= dataCfg_q[mac_cfg_pkg::DC_WORD_SEL];
		end
	end

	// ========================================
	// host read path
	logic [7:0] readMux;

	assign readMux =
		hit(hostAddr, mac_cfg_pkg::OFF_FAE_TALLY)  ? faeTally :
		hit(hostAddr, mac_cfg_pkg::OFF_CRC_TALLY)  ? crcTally :
		hit(hostAddr, mac_cfg_pkg::OFF_INT_STATUS) ? {1'b0, intStat_q} :
		hit(hostAddr, mac_cfg_pkg::OFF_RX_CONFIG)  ? rxCfg_q :
		hit(hostAddr, mac_cfg_pkg::OFF_TX_CONFIG)  ? txCfg_q :
		hit(hostAddr, mac_cfg_pkg::OFF_RX_STATUS)  ? rxStat_q :
		hit(hostAddr, mac_cfg_pkg::OFF_MEDIA_CTRL) ? media_q : 8'h00;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hostDataOut <= 8'h00;
			hostDataOe  <= 1'b0;
		end else begin
			hostDataOut <= rdStrobe ? readMux : 8'h00;
			hostDataOe  <= rdStrobe;
		end
	end

	// ========================================
	// checks
	sequence rxEv(cond);
		rxDone && cond;
	endsequence

	AST_MONITOR_NO_STORE: assert property (@(posedge core_clk) disable iff (rst)
		rxEv(rxCfg_q[mac_cfg_pkg::RC_MONITOR]) |=> !rxStore)
		else $error("stored a packet in monitor mode");
	AST_PROMISC_ACCEPT: assert property (@(posedge core_clk) disable iff (rst)
		rxEv(!rxInfo.multicast && rxCfg_q[mac_cfg_pkg::RC_ALL_PHYS] && !rxInfo.runt
			&& !anyErr) |=> rxAccept)
		else $error("promiscuous packet rejected");
	AST_MCAST_HASH: assert property (@(posedge core_clk) disable iff (rst)
		rxEv(rxInfo.multicast && !rxInfo.broadcast && !rxInfo.hashHit) |=> !rxAccept)
		else $error("multicast accepted without hash hit");
	AST_BCAST_REJECT: assert property (@(posedge core_clk) disable iff (rst)
		rxEv(rxInfo.broadcast && !rxCfg_q[mac_cfg_pkg::RC_BCAST]) |=> !rxAccept)
		else $error("broadcast accepted while disabled");
	AST_RUNT_REJECT: assert property (@(posedge core_clk) disable iff (rst)
		rxEv(rxInfo.runt && !rxCfg_q[mac_cfg_pkg::RC_RUNT]) |=> !rxAccept && !rxStore)
		else $error("runt accepted while disabled");
	AST_ERR_REJECT: assert property (@(posedge core_clk) disable iff (rst)
		rxEv(anyErr && !rxCfg_q[mac_cfg_pkg::RC_SAVE_ERR]) |=> !rxAccept)
		else $error("error packet accepted while disabled");
	AST_DUPLEX_OR: assert property (@(posedge core_clk) disable iff (rst)
		!internalPhyUsed && (txCfg_q[7] || media_q[7]) |=> macCfg.fullDuplex)
		else $error("full duplex not selected");
	AST_PHY_IGNORE: assert property (@(posedge core_clk) disable iff (rst)
		internalPhyUsed |=> !macCfg.fullDuplex)
		else $error("duplex bits honoured with internal phy");
	AST_STICKY_STATUS: assert property (@(posedge core_clk) disable iff (rst)
		intStat_q.txDone && !(wrIntStat && hostDataIn[1]) |=> intStat_q.txDone)
		else $error("status bit lost without write-one clear");
	AST_INT_REQ: assert property (@(posedge core_clk) disable iff (rst)
		wrIntMask && hostDataIn[0] ##1 intStat_q.rxDone && !wrIntStat |=> intReq)
		else $error("enabled status did not raise interrupt");
endmodule : mac_rx_tx_config_regs

// File: hw/tally_counter.sv
// error tally counter that clears on host read
`timescale 1ns/1ps
module tally_counter #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             countEn,
	input  wire logic             readClr,
	output logic [WIDTH-1:0]      count_q,
	output logic                  msbRise_q
);
	logic [WIDTH-1:0] count_d;

	// an event in the read cycle survives the clear
	assign count_d = readClr ? WIDTH'(countEn) : count_q + WIDTH'(countEn);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_q   <= '0;
			msbRise_q <= 1'b0;
		end else begin
			count_q   <= count_d;
			msbRise_q <= count_d[WIDTH-1] & ~count_q[WIDTH-1];
		end
	end

	AST_TALLY_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
		readClr && !countEn |=> count_q == '0)
		else $error("tally not cleared by read");
	AST_TALLY_INC: assert property (@(posedge core_clk) disable iff (rst)
		countEn && !readClr |=> count_q == $past(count_q) + WIDTH'(1))
		else $error("tally did not count once");
endmodule : tally_counter

// File: test/mac_host_model.sv
// host microcontroller model on the sram-like local register bus
`timescale 1ns/1ps
module mac_host_model (
	input  wire logic       core_clk,
	output logic            hostCs,
	output logic            hostRd,
	output logic            hostWr,
	output logic [4:0]      hostAddr,
	output logic [7:0]      hostDataIn,
	input  wire logic [7:0] hostDataOut,
	input  wire logic       hostDataOe
);
	initial begin
		hostCs = 1'b0;
		hostRd = 1'b0;
		hostWr = 1'b0;
		hostAddr = 5'h00;
		hostDataIn = 8'h00;
	end

	// ========================================
	// bus cycles, one strobe cycle each, driven off the falling edge
	task automatic regWrite(input logic [4:0] a, input logic [7:0] d);
		@(negedge core_clk);
		hostCs = 1'b1;
		hostWr = 1'b1;
		hostAddr = a;
		hostDataIn = d;
		@(negedge core_clk);
		hostCs = 1'b0;
		hostWr = 1'b0;
		// released data must not keep showing the written byte
		hostDataIn = ~d;
	endtask : regWrite

	task automatic regRead(input logic [4:0] a, output logic [7:0] d, output logic oe);
		@(negedge core_clk);
		hostCs = 1'b1;
		hostRd = 1'b1;
		hostAddr = a;
		@(negedge core_clk);
		hostCs = 1'b0;
		hostRd = 1'b0;
		d = hostDataOut;
		oe = hostDataOe;
	endtask : regRead
endmodule : mac_host_model

// File: test/mac_rx_tx_config_regs_tb.sv
// self-checking bench of the mac config register bank
`timescale 1ns/1ps
module mac_rx_tx_config_regs_tb;
	logic                  core_clk;
	logic                  rst;
	logic                  hostCs;
	logic                  hostRd;
	logic                  hostWr;
	logic [4:0]            hostAddr;
	logic [7:0]            hostDataIn;
	logic [7:0]            hostDataOut;
	logic                  hostDataOe;
	logic                  rxDone;
	mac_cfg_pkg::rx_info_t rxInfo;
	logic                  rxAccept;
	logic                  rxStore;
	logic                  receiverOff;
	logic                  internalPhyUsed;
	mac_cfg_pkg::mac_cfg_t macCfg;
	logic                  intReq;
	logic [6:0]            ev;
	logic [7:0]            rcfg;
	logic [7:0]            v;
	logic [7:0]            fae;
	logic [7:0]            crc;
	logic [3:0]            ex;
	int                    errTotal;
	int                    nChecks;
	int                    b;
	int                    bits[5] = '{6, 4, 3, 2, 1};

	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	mac_rx_tx_config_regs i_dut (.core_clk(core_clk), .rst(rst), .hostCs(hostCs),
		.hostRd(hostRd), .hostWr(hostWr), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
		.hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .rxDone(rxDone), .rxInfo(rxInfo),
		.rxMissed(ev[2]), .receiverOff(receiverOff), .rxAccept(rxAccept), .rxStore(rxStore),
		.txDone(ev[1]), .txError(ev[3]), .dmaDone(ev[6]), .ringOverrun(ev[4]),
		.internalPhyUsed(internalPhyUsed), .macCfg(macCfg), .intReq(intReq));

	mac_host_model i_host (.core_clk(core_clk), .hostCs(hostCs), .hostRd(hostRd),
		.hostWr(hostWr), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
		.hostDataOut(hostDataOut), .hostDataOe(hostDataOe));

	// ========================================
	// compare and bus helpers
	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		nChecks++;
		if (g !== e) begin
			errTotal++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk8

	task automatic chk1(input logic e, input logic g);
		chk8({7'h00, e}, {7'h00, g});
	endtask : chk1

	task automatic w(input logic [4:0] a, input logic [7:0] d);
		i_host.regWrite(a, d);
	endtask : w

	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       o;
		i_host.regRead(a, d, o);
		chk1(1'b1, o);
		chk8(e, d);
	endtask : rc

	task automatic final_report;
		if (errTotal == 0 && nChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// {accept, store, counted alignment error, counted crc error}
	function automatic logic [3:0] rxExpect(input logic [7:0] c, input mac_cfg_pkg::rx_info_t i);
		logic p;
		logic a;
		p = (i.broadcast & c[2]) | (i.multicast & ~i.broadcast & c[3] & i.hashHit)
			| (~i.multicast & (i.addrMatch | c[4]));
		a = p & (~i.runt | c[1]) & (~(i.crcErr | i.alignErr) | c[0]);
		return {a, a & ~c[5], p & i.alignErr, p & i.crcErr};
	endfunction : rxExpect

	initial begin
		#40000;
		errTotal++;
		final_report();
	end

	// ========================================
	// test sequence
	initial begin
		rst = 1'b1;
		rxDone = 1'b0;
		rxInfo = 7'h00;
		ev = 7'h00;
		receiverOff = 1'b1;
		internalPhyUsed = 1'b0;
		errTotal = 0;
		nChecks = 0;
		fae = 8'h00;
		crc = 8'h00;
		v = 8'($urandom(32'h55E5));
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		chk1(1'b0, |macCfg);
		foreach (bits[j]) rc(5'(bits[j] * 5), (bits[j] == 6) ? 8'h40 : 8'h00);
		rc(5'h0F, 8'h00);
		rc(5'h0E, 8'h00);
		w(5'h05, 8'hFF);
		rc(5'h05, 8'h00);
		w(5'h0E, 8'hFF);
		repeat (3) @(negedge core_clk);
		chk1(1'b1, macCfg.dataPortWordSel);
		rc(5'h0E, 8'h00);
		w(5'h0E, 8'h00);
		repeat (3) @(negedge core_clk);
		chk1(1'b0, macCfg.dataPortWordSel);
		for (int k = 0; k < 6; k++) begin
			v = 8'($urandom);
			if (k < 4) v[2:1] = 2'(k);
			w(5'h1D, v);
			rc(5'h1D, v & 8'hE7);
			repeat (3) @(negedge core_clk);
			chk1(v[6], macCfg.padDisable);
			chk1(v[5], macCfg.lateCollisionRetry);
			chk8({6'h00, v[2:1]}, {6'h00, macCfg.loopbackMode});
			chk1(v[0], macCfg.crcInhibit);
		end
		for (int k = 0; k < 8; k++) begin
			w(5'h1D, {k[2], 7'h00});
			w(5'h1F, {k[1], 7'h00});
			internalPhyUsed = k[0];
			repeat (3) @(negedge core_clk);
			chk1((k[2] | k[1]) & ~k[0], macCfg.fullDuplex);
		end
		for (int r = 0; r < 8; r++) begin
			rcfg = (r == 0) ? 8'h00 : (r == 1) ? 8'h3F : 8'($urandom);
			w(5'h1C, rcfg);
			rcfg &= 8'h3F;
			rc(5'h1C, rcfg);
			chk8(rcfg, {2'b00, macCfg[12:7]});
			for (int k = 0; k <= 12; k++) begin
				@(negedge core_clk);
				if (k > 0) chk1(ex[3], rxAccept);
				if (k > 0) chk1(ex[2], rxStore);
				rxDone = (k < 12);
				rxInfo = 7'($urandom);
				ex = rxExpect(rcfg, rxInfo);
				if (k < 12) fae += 8'(ex[1]);
				if (k < 12) crc += 8'(ex[0]);
			end
		end
		rc(5'h0D, fae);
		rc(5'h0E, crc);
		rc(5'h0D, 8'h00);
		rc(5'h0E, 8'h00);
		w(5'h0F, 8'h7F);
		@(negedge core_clk);
		chk1(1'b1, intReq);
		w(5'h07, 8'hFF);
		foreach (bits[j]) begin
			b = bits[j];
			@(negedge core_clk);
			ev[b] = 1'b1;
			@(negedge core_clk);
			ev = 7'h00;
			repeat (2) @(negedge core_clk);
			chk1(1'b1, intReq);
			rc(5'h07, 8'h01 << b);
			if (b == 2) i_host.regRead(5'h1E, v, rcfg[0]);
			if (b == 2) chk8(8'h50, v & 8'h50);
			w(5'h07, 8'h01 << b);
			rc(5'h07, 8'h00);
			chk1(1'b0, intReq);
		end
		w(5'h0F, 8'h20);
		w(5'h1C, 8'h00);
		rxInfo = 7'h12;
		for (int k = 0; k <= 128; k++) begin
			@(negedge core_clk);
			rxDone = (k < 128);
		end
		repeat (3) @(negedge core_clk);
		chk1(1'b1, intReq);
		rc(5'h07, 8'h24);
		rc(5'h0E, 8'h80);
		rc(5'h1E, 8'h42);
		w(5'h07, 8'hFF);
		w(5'h0F, 8'h00);
		@(negedge core_clk);
		ev[1] = 1'b1;
		@(negedge core_clk);
		ev = 7'h00;
		repeat (2) @(negedge core_clk);
		chk1(1'b0, intReq);
		rc(5'h07, 8'h02);
		final_report();
	end
endmodule : mac_rx_tx_config_regs_tb
